// [dma_buffer_ram_map.vh]
// constants for the dual-ported dma buffer ram
`ifndef DMA_BUFFER_RAM_MAP_VH
`define DMA_BUFFER_RAM_MAP_VH
`define DBR_DATA_W 16
`define DBR_BYTES 2048
`define DBR_ADDR_W 16
`define DBR_WORD_ADDR_W 10
`define DBR_BASE 16'hf800
`define DBR_LANE_LO 1'b0
`define DBR_LANE_HI 1'b1
`define DBR_RDATA_RST 16'h0000
`define DBR_FLAG_RST 1'b0
`define DBR_ZERO_BYTE 8'h00
`endif

// [dma_buffer_ram.v]
// dual-ported buffer ram shared by the cpu data path and the dma controller
`include "dma_buffer_ram_map.vh"

// one byte lane of storage with write arbitration and read taps
module dbr_lane #(
   parameter WORD_AW = `DBR_WORD_ADDR_W
) (
   input wire mclk_in,
   input wire ce_in,
   input wire cpu_wr_in,
   input wire [WORD_AW-1:0] cpu_wa_in,
   input wire [7:0] cpu_d_in,
   input wire dma_wr_in,
   input wire [WORD_AW-1:0] dma_wa_in,
   input wire [7:0] dma_d_in,
   output wire [7:0] cpu_q_out,
   output wire [7:0] dma_q_out
);
   localparam DEPTH = 1 << WORD_AW;

   reg [7:0] mem [0:DEPTH-1];

   wire same_word;
   wire dma_keep;

   assign same_word = (cpu_wa_in == dma_wa_in);
   // a dma write loses this lane silently when the cpu writes the same word of it too
   assign dma_keep = dma_wr_in && !(cpu_wr_in && same_word);

   // storage has no reset; contents are undefined until written
   always @(posedge mclk_in) begin
      if (ce_in) begin
         if (cpu_wr_in) begin
            mem[cpu_wa_in] <= cpu_d_in;
         end
         if (dma_keep) begin
            mem[dma_wa_in] <= dma_d_in;
         end
      end
   end

   // read taps see the old word during a same-cycle write
   assign cpu_q_out = mem[cpu_wa_in];
   assign dma_q_out = mem[dma_wa_in];
endmodule

// lane strobes, lane data and read formatting of one access port
module dbr_port_decode (
   input wire req_in,
   input wire we_in,
   input wire byte_in,
   input wire odd_in,
   input wire [`DBR_DATA_W-1:0] wdata_in,
   input wire [7:0] q_lo_in,
   input wire [7:0] q_hi_in,
   output wire wr_lo_out,
   output wire wr_hi_out,
   output wire rd_out,
   output wire [7:0] d_lo_out,
   output wire [7:0] d_hi_out,
   output wire [`DBR_DATA_W-1:0] q_out
);
   wire byte_lo;
   wire byte_hi;
   wire [7:0] q_byte;

   // a byte access names one lane, a word access both
   assign byte_lo = byte_in && (odd_in == `DBR_LANE_LO);
   assign byte_hi = byte_in && (odd_in == `DBR_LANE_HI);
   assign wr_lo_out = req_in && we_in && (!byte_in || byte_lo);
   assign wr_hi_out = req_in && we_in && (!byte_in || byte_hi);
   assign rd_out = req_in && !we_in;

   // a byte write carries its data in the low lane of the bus
   assign d_lo_out = wdata_in[7:0];
   assign d_hi_out = byte_in ? wdata_in[7:0] : wdata_in[15:8];

   // a byte read returns the selected byte zero-extended
   assign q_byte = odd_in ? q_hi_in : q_lo_in;
   assign q_out = byte_in ? {`DBR_ZERO_BYTE, q_byte} : {q_hi_in, q_lo_in};
endmodule

module dma_buffer_ram #(
   parameter [`DBR_ADDR_W-1:0] BASE = `DBR_BASE,
   parameter WORD_AW = `DBR_WORD_ADDR_W
) (
   input wire mclk_in,
   input wire nrst_in,
   input wire ce_in,
   input wire cpu_en_in,
   input wire cpu_we_in,
   input wire cpu_byte_in,
   input wire [`DBR_ADDR_W-1:0] cpu_addr_in,
   input wire [`DBR_DATA_W-1:0] cpu_wdata_in,
   output reg [`DBR_DATA_W-1:0] cpu_rdata_out,
   output reg cpu_hit_out,
   output reg cpu_wait_out,
   input wire dma_en_in,
   input wire dma_we_in,
   input wire dma_byte_in,
   input wire [WORD_AW:0] dma_addr_in,
   input wire [`DBR_DATA_W-1:0] dma_wdata_in,
   output reg [`DBR_DATA_W-1:0] dma_rdata_out
);
   localparam DEPTH = 1 << WORD_AW;
   localparam [31:0] SPAN_I = DEPTH * 2;
   localparam [`DBR_ADDR_W-1:0] SPAN = SPAN_I[`DBR_ADDR_W-1:0];
   localparam [`DBR_ADDR_W-1:0] BASE_W = BASE;

   wire [`DBR_ADDR_W-1:0] cpu_off;
   wire cpu_in_win;
   wire cpu_sel;
   wire [WORD_AW-1:0] cpu_wa;
   wire [WORD_AW-1:0] dma_wa;
   wire cpu_wr_lo;
   wire cpu_wr_hi;
   wire cpu_rd;
   wire dma_wr_lo;
   wire dma_wr_hi;
   wire dma_rd;
   wire [7:0] cpu_d_lo;
   wire [7:0] cpu_d_hi;
   wire [7:0] dma_d_lo;
   wire [7:0] dma_d_hi;
   wire [7:0] cpu_q_lo;
   wire [7:0] cpu_q_hi;
   wire [7:0] dma_q_lo;
   wire [7:0] dma_q_hi;
   wire [`DBR_DATA_W-1:0] cpu_q;
   wire [`DBR_DATA_W-1:0] dma_q;

   assign cpu_off = cpu_addr_in - BASE_W;
   // decoded as part of y space: only the top window hits
   assign cpu_in_win = (cpu_addr_in >= BASE_W) && (cpu_off < SPAN);
   assign cpu_sel = cpu_en_in && cpu_in_win;
   assign cpu_wa = cpu_off[WORD_AW:1];
   assign dma_wa = dma_addr_in[WORD_AW:1];

   dbr_port_decode cpu_port (
      .req_in(cpu_sel),
      .we_in(cpu_we_in),
      .byte_in(cpu_byte_in),
      .odd_in(cpu_off[0]),
      .wdata_in(cpu_wdata_in),
      .q_lo_in(cpu_q_lo),
      .q_hi_in(cpu_q_hi),
      .wr_lo_out(cpu_wr_lo),
      .wr_hi_out(cpu_wr_hi),
      .rd_out(cpu_rd),
      .d_lo_out(cpu_d_lo),
      .d_hi_out(cpu_d_hi),
      .q_out(cpu_q)
   );

   // the dma port serves writes from and reads for peripherals
   dbr_port_decode dma_port (
      .req_in(dma_en_in),
      .we_in(dma_we_in),
      .byte_in(dma_byte_in),
      .odd_in(dma_addr_in[0]),
      .wdata_in(dma_wdata_in),
      .q_lo_in(dma_q_lo),
      .q_hi_in(dma_q_hi),
      .wr_lo_out(dma_wr_lo),
      .wr_hi_out(dma_wr_hi),
      .rd_out(dma_rd),
      .d_lo_out(dma_d_lo),
      .d_hi_out(dma_d_hi),
      .q_out(dma_q)
   );

   // separate write lines per lane over the shared word decode
   dbr_lane #(
      .WORD_AW(WORD_AW)
   ) lane_lo (
      .mclk_in(mclk_in),
      .ce_in(ce_in),
      .cpu_wr_in(cpu_wr_lo),
      .cpu_wa_in(cpu_wa),
      .cpu_d_in(cpu_d_lo),
      .dma_wr_in(dma_wr_lo),
      .dma_wa_in(dma_wa),
      .dma_d_in(dma_d_lo),
      .cpu_q_out(cpu_q_lo),
      .dma_q_out(dma_q_lo)
   );

   dbr_lane #(
      .WORD_AW(WORD_AW)
   ) lane_hi (
      .mclk_in(mclk_in),
      .ce_in(ce_in),
      .cpu_wr_in(cpu_wr_hi),
      .cpu_wa_in(cpu_wa),
      .cpu_d_in(cpu_d_hi),
      .dma_wr_in(dma_wr_hi),
      .dma_wa_in(dma_wa),
      .dma_d_in(dma_d_hi),
      .cpu_q_out(cpu_q_hi),
      .dma_q_out(dma_q_hi)
   );

   // registered reads; each read data holds until the next read
   always @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cpu_rdata_out <= `DBR_RDATA_RST;
         dma_rdata_out <= `DBR_RDATA_RST;
         cpu_hit_out <= `DBR_FLAG_RST;
         cpu_wait_out <= `DBR_FLAG_RST;
      end else if (ce_in) begin
         // the buffer never holds the cpu back
         cpu_wait_out <= 1'b0;
         cpu_hit_out <= cpu_sel;
         if (cpu_rd) begin
            cpu_rdata_out <= cpu_q;
         end
         if (dma_rd) begin
            dma_rdata_out <= dma_q;
         end
      end
   end
endmodule

// [dbr_checker.sv]
// assertions on the buffer ram ports
module dbr_checker (
   input wire mclk_in,
   input wire nrst_in,
   input wire ce_in,
   input wire cpu_en_in,
   input wire cpu_we_in,
   input wire cpu_byte_in,
   input wire cpu_hit_out,
   input wire cpu_wait_out,
   input wire dma_en_in,
   input wire dma_we_in,
   input wire [15:0] cpu_addr_in,
   input wire [15:0] cpu_rdata_out,
   input wire [15:0] dma_rdata_out
);
   wire h = cpu_addr_in[15:11] == 5'h1f;
   wire c = ce_in & cpu_en_in & !cpu_we_in & h;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   no_stall_a: assert property (!cpu_wait_out)
      else $error("cpu stalled");
   hit_flag_a: assert property ($past(ce_in) |->
      cpu_hit_out == $past(cpu_en_in & h)) else $error("hit flag wrong");
   cpu_hold_a: assert property (!$past(c) |-> $stable(cpu_rdata_out))
      else $error("cpu read data moved");
   cpu_zext_a: assert property ($past(c & cpu_byte_in) |->
      cpu_rdata_out[15:8] == 8'h00) else $error("byte read not extended");
   dma_hold_a: assert property ($past(dma_we_in | !dma_en_in | !ce_in)
      |-> $stable(dma_rdata_out)) else $error("dma read data moved");
   ce_hold_a: assert property (!$past(ce_in) |-> $stable(cpu_hit_out))
      else $error("hit flag moved while frozen");
endmodule
bind dma_buffer_ram dbr_checker chk (.*);

// [dma_requester.sv]
// dma controller side: one request per clock, set after the edge
module dma_requester(output logic dma_en_in=0,dma_we_in=0,dma_byte_in=0,
output logic [10:0] dma_addr_in=0,output logic [15:0] dma_wdata_in=0);
   task req(input [29:0] v);
      {dma_en_in,dma_we_in,dma_byte_in,dma_addr_in,dma_wdata_in}=v;
   endtask
endmodule

// [dual_port_dma_buffer_ram_tb.sv]
// self-checking bench for the dual-ported buffer ram
module dual_port_dma_buffer_ram_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_in=0,nrst_in=0,ce_in=1,cpu_en_in=0,cpu_we_in=0,cpu_byte_in=0;
   logic h,he=0;
   logic [15:0] cpu_addr_in=0,cpu_wdata_in=0,ec=0,ed=0,p,q,w[1024];
   logic [31:0] r;
   wire [15:0] cpu_rdata_out,dma_rdata_out,dma_wdata_in;
   wire [10:0] dma_addr_in;
   wire cpu_hit_out,cpu_wait_out,dma_en_in,dma_we_in,dma_byte_in;
   int miscompares=0,compares=0;
   always #5 mclk_in=~mclk_in;
   dma_requester dma(.*);
   dma_buffer_ram uut(.*);
   function [15:0] m(input [15:0] o,v,input b,a);
      return b?(a?{v[7:0],o[7:0]}:{o[15:8],v[7:0]}):v;
   endfunction
   task chk(input [15:0] g,e);
      compares++;
      miscompares+=g!==e;
      if (g!==e) $display("MISMATCH %0t %h %h",$time,g,e);
   endtask
   task print_verdict;
      if (miscompares==0&&compares>0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task step(input [34:0] c,input [29:0] d);
      {cpu_en_in,cpu_we_in,cpu_byte_in,cpu_addr_in,cpu_wdata_in}=c;
      dma.req(d);
      h=c[34]&c[31:27]==5'h1f;
      p=w[c[26:17]];
      q=w[d[26:17]];
      if (ce_in) begin
         he=h;
         if (h&!c[33]) ec=c[32]?(c[16]?p>>8:p&16'hff):p;
         if (d[29]&!d[28]) ed=d[27]?(d[16]?q>>8:q&16'hff):q;
         if (d[29]&d[28]) w[d[26:17]]=m(q,d[15:0],d[27],d[16]);
         if (h&c[33]) w[c[26:17]]=m(w[c[26:17]],c[15:0],c[32],c[16]);
      end
      @(posedge mclk_in) #1;
      chk(cpu_rdata_out,ec);
      chk(dma_rdata_out,ed);
      chk(cpu_hit_out,he);
      chk(cpu_wait_out,0);
   endtask
   initial begin
      void'($urandom(32'hd481eac1));
      repeat (10) @(posedge mclk_in);
      #1 nrst_in=1;
      for (int k=0;k<16;k++) begin
         r=$urandom;
         step(0,{3'h6,{6{k[3]}},k[3:0],1'b0,r[15:0]});
      end
      for (int n=0;n<3000;n++) begin
         r=$urandom;
         ce_in=$urandom%8!=0;
         step({r[20:18],r[2]?5'h1f:5'h0f,{6{r[6]}},r[6:3],r[7]&r[18],r[15:0]},
            {r[10:8],{6{r[17]}},r[17:14],r[21]&r[8],r[31:16]});
         if (n==1500) begin
            // mid-run reset: outputs clear, storage is kept
            nrst_in=0;
            ce_in=1;
            cpu_en_in=0;
            dma.req(0);
            @(posedge mclk_in) #1;
            chk(cpu_rdata_out,0);
            chk(dma_rdata_out,0);
            chk(cpu_hit_out,0);
            nrst_in=1;
            ec=0;
            ed=0;
            he=0;
         end
      end
      print_verdict;
   end
endmodule
